// ---- sar_adc_conversion_control.sv ----
// Successive-approximation conversion sequencer with tri-state output control
//
// Function
// - Unipolar result is straight binary, all zeros at zero input.
// - Bipolar result is offset binary, mid-scale code at zero input.
// - Each parallel result bit is active high.
// - Conversion timing comes from external clock or internal oscillator.
// - Internal oscillator starts on start rise and runs only while converting.
// - Start rise sets MSB trial, clears others, drops done, enables serial.
// - Done stays high; run/stop raise restarts with free-running clock.
// - Run dropped mid-conversion: finish the conversion, then idle.
// - Run/stop with external clock: start accepted only when not converting.
// - Done looped to start gives thirteen clocks per twelve-bit conversion.
// - Internal clock is visible on the oscillator node outputs.
// - Done rises together with the last bit decision.
// - Short select low stops after eight bits; high resolves twelve.
// - Byte and done enables float their group when low.
// - Serial data shows each decision; strobe rises at stable data.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_conversion_control
   import sar_ctrl_pkg::*;
#(
   parameter int OSC_HALF = OSC_HALF_CYC,
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic START_I,
   input wire logic COMP_I,
   input wire logic EXT_CLK_I,
   input wire logic CLOCK_SOURCE_I,
   input wire logic RUN_STOP_MODE_I,
   input wire logic SHORT_CONVERSION_SELECT_I,
   input wire logic LOW_BYTE_OUTPUT_ENABLE_I,
   input wire logic HIGH_BYTE_OUTPUT_ENABLE_I,
   input wire logic DONE_FLAG_OUTPUT_ENABLE_I,
   output logic [11:0] RESULT_BITS_O,
   output logic RESULT_LOW_OE_O,
   output logic RESULT_HIGH_OE_O,
   output logic DONE_O,
   output logic DONE_OE_O,
   output logic SERIAL_RESULT_OUT_O,
   output logic SERIAL_STROBE_O,
   output logic SERIAL_OE_O,
   output logic OSCILLATOR_NODE_A_O,
   output logic OSCILLATOR_NODE_B_O,
   output logic RESULT_VALID_O,
   input wire logic RESULT_READY_I,
   output logic [11:0] RESULT_DATA_O
);

   if (OSC_HALF < 1 || FIFO_DEPTH < 2) begin : g_chk
      $error("oscillator half period or buffer depth out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and edge detection

   logic [PIN_W-1:0] pins_s;
   logic start_s, comp_s, ext_s, internal_s, run_stop_s;
   logic short_s, low_s, high_s, done_en_s;
   logic start_d, ext_d;
   logic start_rise, ext_rise;

   pin_sync #(.W(PIN_W)) u_sync (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .async_i({START_I, COMP_I, EXT_CLK_I, CLOCK_SOURCE_I, RUN_STOP_MODE_I,
                SHORT_CONVERSION_SELECT_I, LOW_BYTE_OUTPUT_ENABLE_I,
                HIGH_BYTE_OUTPUT_ENABLE_I, DONE_FLAG_OUTPUT_ENABLE_I}),
      .sync_o(pins_s)
   );

   assign {start_s, comp_s, ext_s, internal_s, run_stop_s,
           short_s, low_s, high_s, done_en_s} = pins_s;

   // Previous values for edge detection, taken from the synced copies
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         start_d <= 1'b0;
         ext_d <= 1'b0;
      end else begin
         start_d <= start_s;
         ext_d <= ext_s;
      end
   end

   assign start_rise = start_s & ~start_d;
   assign ext_rise = ext_s & ~ext_d;

   ////////////////////////////////////////////////////////////////////////
   // Internal oscillator, gated by the conversion

   localparam int OW = $clog2(OSC_HALF + 1);

   logic osc_run;
   logic osc_clk;
   logic [OW-1:0] osc_cnt;
   logic osc_rise;
   logic tick;

   assign osc_rise = osc_run & ~osc_clk & (osc_cnt == OW'(OSC_HALF - 1));
   // Conversion step source follows the clock select
   assign tick = internal_s ? osc_rise : ext_rise;

   // Toggles only while osc_run is set; parks low otherwise
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I || !osc_run) begin
         osc_cnt <= '0;
         osc_clk <= 1'b0;
      end else if (osc_cnt == OW'(OSC_HALF - 1)) begin
         osc_cnt <= '0;
         osc_clk <= ~osc_clk;
      end else begin
         osc_cnt <= osc_cnt + OW'(1);
      end
   end

   // Oscillator node mirrors; the second node idles high like an RC pair
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         OSCILLATOR_NODE_A_O <= 1'b0;
         OSCILLATOR_NODE_B_O <= 1'b1;
      end else begin
         OSCILLATOR_NODE_A_O <= osc_clk;
         OSCILLATOR_NODE_B_O <= ~osc_clk;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer

   conv_state_t state;
   logic [11:0] sar;
   logic [11:0] trial;
   logic last;
   logic [11:0] next_sar;
   logic busy;
   logic fifo_ready;
   logic start_ok;
   logic restart;
   logic push;

   // Last decision depends on the truncation select
   assign last = trial[0] | (~short_s & trial[DATA_W-SHORT_BITS]);
   // Keep or drop the trial bit, then arm the next lower one
   assign next_sar = (sar & ~trial) | (comp_s ? trial : '0)
                     | (last ? '0 : (trial >> 1));
   assign busy = (state == ST_ARM) || (state == ST_CONV);
   // Run/stop never aborts; a full buffer holds off new work
   assign start_ok = start_rise & fifo_ready
                     & ~(run_stop_s & busy);
   // Free-running restart while run is held high
   assign restart = (state == ST_TAIL) & tick & run_stop_s & start_s
                    & fifo_ready;

   // Main state and word; SAR output is the natural binary weight of the
   // word, which is straight binary unipolar and offset binary bipolar
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         state <= ST_IDLE;
         sar <= RESULT_RESET;
         trial <= '0;
         DONE_O <= 1'b0;
         push <= 1'b0;
      end else begin
         push <= 1'b0;
         if (start_ok || restart) begin
            state <= start_ok ? ST_ARM : ST_CONV;
            sar <= MSB_TRIAL;
            trial <= MSB_TRIAL;
            DONE_O <= 1'b0;
         end else begin
            unique case (state)
               ST_IDLE: begin
               end
               ST_ARM: begin
                  // Start high parks the MSB trial unless in run/stop mode
                  if (tick && (!start_s || run_stop_s)) begin
                     state <= ST_CONV;
                  end
               end
               ST_CONV: begin
                  if (tick) begin
                     sar <= next_sar;
                     trial <= trial >> 1;
                     if (last) begin
                        DONE_O <= 1'b1;
                        push <= 1'b1;
                        state <= ST_TAIL;
                     end
                  end
               end
               ST_TAIL: begin
                  if (tick) begin
                     state <= ST_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // Oscillator gate: on at start with internal clock, off after the tail
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         osc_run <= 1'b0;
      end else if (start_ok) begin
         osc_run <= internal_s;
      end else if (state == ST_TAIL && tick && !restart) begin
         osc_run <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Serial stream: data changes on a tick, strobe low for that cycle so
   // its rising edge always lands on settled data

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         SERIAL_OE_O <= 1'b0;
         SERIAL_RESULT_OUT_O <= 1'b0;
         SERIAL_STROBE_O <= 1'b0;
      end else begin
         if (start_ok) begin
            SERIAL_OE_O <= 1'b1;
         end else if (state == ST_TAIL && tick && !restart) begin
            SERIAL_OE_O <= 1'b0;
         end
         if (state == ST_CONV && tick) begin
            SERIAL_RESULT_OUT_O <= comp_s;
         end
         SERIAL_STROBE_O <= ~tick & (state == ST_TAIL
                            || (state == ST_CONV && trial != MSB_TRIAL));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Parallel word and output enables; the word pins are the SAR flops
   // themselves so the last decision and done appear on one edge
   assign RESULT_BITS_O = sar;

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         RESULT_LOW_OE_O <= 1'b0;
         RESULT_HIGH_OE_O <= 1'b0;
         DONE_OE_O <= 1'b0;
      end else begin
         RESULT_LOW_OE_O <= low_s;
         RESULT_HIGH_OE_O <= high_s;
         DONE_OE_O <= done_en_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Finished words queue for the stream consumer

   result_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .in_valid_i(push),
      .in_ready_o(fifo_ready),
      .in_data_i(sar),
      .out_valid_o(RESULT_VALID_O),
      .out_ready_i(RESULT_READY_I),
      .out_data_o(RESULT_DATA_O)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks

   // Decision ticks since the last start, for the cycle-count check
   logic [4:0] tick_cnt;
   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I || start_ok || restart) begin
         tick_cnt <= '0;
      end else if (tick && state == ST_CONV && tick_cnt != 5'h1F) begin
         tick_cnt <= tick_cnt + 5'h01;
      end
   end

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   sequence s_launch;
      start_ok;
   endsequence

   sequence s_armed;
      (sar == MSB_TRIAL) && !DONE_O && SERIAL_OE_O && state == ST_ARM;
   endsequence

   start_arm_a: assert property (s_launch |=> s_armed)
      else $error("start did not arm the top trial");

   done_count_a: assert property ($rose(DONE_O) |->
      tick_cnt == (short_s ? TICKS_FULL - 5'h01 : TICKS_SHORT - 5'h01)
      || tick_cnt == (short_s ? TICKS_FULL : TICKS_SHORT) - 5'h01)
      else $error("done rose after the wrong number of ticks");

   done_lsb_a: assert property ($rose(DONE_O) |->
      $past(state == ST_CONV && tick && last))
      else $error("done not aligned with the last decision");

   short_zero_a: assert property ($rose(DONE_O) && !short_s |->
      sar[3:0] == 4'h0)
      else $error("short conversion left low bits set");

   osc_gate_a: assert property ($rose(osc_clk) |-> $past(osc_run))
      else $error("oscillator toggled outside a conversion");

   done_hold_a: assert property (DONE_O && !start_ok && !restart
      |=> DONE_O)
      else $error("done flag dropped without a start");

   run_guard_a: assert property (run_stop_s && state == ST_CONV
      && !tick |=> state == ST_CONV)
      else $error("run control aborted a conversion");

   serial_float_a: assert property (state == ST_TAIL && tick && !restart
      |=> !SERIAL_OE_O ##1 !SERIAL_STROBE_O)
      else $error("serial outputs still driven after the tail");

   oe_follow_a: assert property (low_s ##1 low_s |-> RESULT_LOW_OE_O)
      else $error("low byte enable did not follow its input");

endmodule // sar_adc_conversion_control

`default_nettype wire

// ---- sar_ctrl_pkg.sv ----
// Shared constants and types for the successive-approximation control block
package sar_ctrl_pkg;

   // Result word width and the truncated conversion length
   localparam int DATA_W = 12;
   localparam int SHORT_BITS = 8;

   // Value of the result word after reset
   localparam logic [11:0] RESULT_RESET = 12'h000;

   // First trial of a conversion: top bit set, all others clear
   localparam logic [11:0] MSB_TRIAL = 12'h800;

   // Ticks from a start to the completion flag (one setup tick + decisions)
   localparam logic [4:0] TICKS_FULL = 5'h0D;
   localparam logic [4:0] TICKS_SHORT = 5'h09;

   // System clock and the internal oscillator half period
   localparam int SYS_CLK_PERIOD_NS = 5;
   localparam int OSC_HALF_NS = 40;
   localparam int OSC_HALF_CYC = (OSC_HALF_NS + SYS_CLK_PERIOD_NS - 1)
                                 / SYS_CLK_PERIOD_NS;

   // Depth of the result buffer
   localparam int FIFO_DEPTH_DEF = 4;

   // Number of pin inputs brought through the synchroniser
   localparam int PIN_W = 9;

   // Conversion sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_ARM,
      ST_CONV,
      ST_TAIL
   } conv_state_t;

endpackage

// ---- pin_sync.sv ----
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] async_i,
   output logic [W-1:0] sync_o
);

   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         meta <= '0;
         sync_o <= '0;
      end else begin
         meta <= async_i;
         sync_o <= meta;
      end
   end

endmodule // pin_sync

`default_nettype wire

// ---- result_fifo.sv ----
// Shift-style result FIFO with registered head word and valid
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
   parameter int W = 12,
   parameter int DEPTH = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);

   localparam int CW = $clog2(DEPTH + 1);

   logic [W-1:0] mem [DEPTH];
   logic [CW-1:0] count;
   logic push;
   logic pop;
   logic [CW-1:0] next_count;
   logic [CW-1:0] wr_idx;

   if (DEPTH < 2) begin : g_chk
      $error("result_fifo needs a depth of at least two");
   end

   // Handshakes; head of queue sits in mem[0] so it comes from a flop
   assign in_ready_o = (count != CW'(DEPTH));
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign next_count = count + CW'(push) - CW'(pop);
   assign wr_idx = count - CW'(pop);
   assign out_data_o = mem[0];

   // Occupancy and registered valid
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= '0;
         out_valid_o <= 1'b0;
      end else begin
         count <= next_count;
         out_valid_o <= (next_count != '0);
      end
   end

   // Storage: shift down on pop, write behind the last live entry
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (push && wr_idx == CW'(i)) begin
            mem[i] <= in_data_i;
         end else if (pop && i < DEPTH - 1) begin
            mem[i] <= mem[i+1];
         end
      end
   end

endmodule // result_fifo

`default_nettype wire

// ---- sar_host_model.sv ----
// Host and comparator model that faces the conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module sar_host_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic go_i,
   input wire logic run_i,
   input wire logic ext_en_i,
   input wire logic [11:0] trial_i,
   input wire logic [11:0] target_i,
   output logic start_o,
   output logic comp_o,
   output logic ext_clk_o
);
   int ext_cnt;
   int pulse_cnt;
   logic pulse;

   ////////////////////////////////////////////////////////////////////////
   // Ideal comparator: keep the trial while it does not pass the input
   assign comp_o = (trial_i <= target_i);
   // Run level of run/stop mode overrides the single pulse
   assign start_o = pulse | run_i;

   ////////////////////////////////////////////////////////////////////////
   // External clock, 1.5 us half period so a legal start fits one low
   // phase; stands low while disabled
   always_ff @(posedge clk_i) begin
      if (rst_i || !ext_en_i) begin
         ext_cnt <= 0;
         ext_clk_o <= 1'b0;
      end else if (ext_cnt == 299) begin
         ext_cnt <= 0;
         ext_clk_o <= ~ext_clk_o;
      end else begin
         ext_cnt <= ext_cnt + 1;
      end
   end

   // Start pulse: rises 200 ns into the low phase, held 800 ns, so it
   // falls 500 ns before the next clock rise
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse <= 1'b0;
         pulse_cnt <= -1;
      end else if (go_i) begin
         pulse_cnt <= 0;
      end else if (pulse_cnt == 0) begin
         if (!ext_en_i || (!ext_clk_o && ext_cnt == 40)) begin
            pulse <= 1'b1;
            pulse_cnt <= 1;
         end
      end else if (pulse_cnt == 160) begin
         pulse <= 1'b0;
         pulse_cnt <= -1;
      end else if (pulse_cnt > 0) begin
         pulse_cnt <= pulse_cnt + 1;
      end
   end
endmodule // sar_host_model

`default_nettype wire

// ---- sar_adc_conversion_control_bench.sv ----
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none

module sar_adc_conversion_control_bench
   import sar_ctrl_pkg::*;
;
   logic clk = 1'b0, rst = 1'b1, src = 1'b1, rs = 1'b0, full = 1'b1;
   logic low_en = 1'b1, high_en = 1'b1, done_en = 1'b1, ready = 1'b0;
   logic go = 1'b0, run = 1'b0, ext_en = 1'b0;
   logic start, comp, ext_clk, done, low_oe, high_oe, done_oe;
   logic ser, strobe, ser_oe, osc_a, osc_b, valid;
   logic [11:0] bits, data, tgt = 12'h000;
   int n_mismatch = 0, n_checks = 0;

   // 200 MHz system clock
   always #2.5 clk = ~clk;

   // Oscillator half period of 16 cycles, twice the package default of 8
   sar_adc_conversion_control #(.OSC_HALF(16), .FIFO_DEPTH(4)) uut (
      .SYS_CLK_I(clk), .RST_I(rst), .START_I(start), .COMP_I(comp),
      .EXT_CLK_I(ext_clk), .CLOCK_SOURCE_I(src), .RUN_STOP_MODE_I(rs),
      .SHORT_CONVERSION_SELECT_I(full), .LOW_BYTE_OUTPUT_ENABLE_I(low_en),
      .HIGH_BYTE_OUTPUT_ENABLE_I(high_en),
      .DONE_FLAG_OUTPUT_ENABLE_I(done_en), .RESULT_BITS_O(bits),
      .RESULT_LOW_OE_O(low_oe), .RESULT_HIGH_OE_O(high_oe), .DONE_O(done),
      .DONE_OE_O(done_oe), .SERIAL_RESULT_OUT_O(ser),
      .SERIAL_STROBE_O(strobe), .SERIAL_OE_O(ser_oe),
      .OSCILLATOR_NODE_A_O(osc_a), .OSCILLATOR_NODE_B_O(osc_b),
      .RESULT_VALID_O(valid), .RESULT_READY_I(ready), .RESULT_DATA_O(data));

   sar_host_model host (.clk_i(clk), .rst_i(rst), .go_i(go), .run_i(run),
      .ext_en_i(ext_en), .trial_i(bits), .target_i(tgt), .start_o(start),
      .comp_o(comp), .ext_clk_o(ext_clk));

   ////////////////////////////////////////////////////////////////////////
   // Shared helpers
   task automatic check(input logic [11:0] got, input logic [11:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Bounded wait for done (sel 0) or serial enable (sel 1)
   task automatic wait_for(input int sel, input logic lvl, input int lim);
      int i;
      for (i = 0; i < lim; i++) begin
         if ((sel ? ser_oe : done) === lvl) break;
         @(posedge clk);
      end
      if (i == lim) begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, ~lvl, lvl);
         finish_test();
      end
   endtask

   task automatic pop(input logic [11:0] exp);
      check({11'h000, valid}, 12'h001);
      check(data, exp);
      ready <= 1'b1;
      @(posedge clk);
      ready <= 1'b0;
      cyc(3);
   endtask

   // One conversion, serial capture on strobe rises, then drain the word
   task automatic run_conv(input logic [11:0] t, input logic [11:0] exp,
                           input int sb);
      logic [11:0] sh = 12'h000;
      logic ps = 1'b1;
      logic pa = 1'b0;
      int osc = 0;
      int k = 0;
      @(posedge clk);
      tgt <= t;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      wait_for(1, 1'b1, 600);
      cyc(2);
      check(bits, MSB_TRIAL);
      check({11'h000, done}, 12'h000);
      for (int i = 0; i < 8000 && k < 3; i++) begin
         @(posedge clk);
         if (strobe === 1'b1 && ps !== 1'b1 && ser_oe === 1'b1)
            sh = {sh[10:0], ser};
         if (osc_a === 1'b1 && pa !== 1'b1) osc++;
         ps = strobe;
         pa = osc_a;
         if (done === 1'b1) k++;
      end
      check(bits, exp);
      check(sh << (12 - sb), exp);
      if (src) check({11'h000, osc > 12}, 12'h001);
      wait_for(1, 1'b0, 1000);
      check({11'h000, done}, 12'h001);
      cyc(2);
      osc = 0;
      for (int i = 0; i < 40; i++) begin
         @(posedge clk);
         if (osc_a !== 1'b0) osc++;
      end
      check(osc[11:0], 12'h000);
      pop(exp);
      check({11'h000, valid}, 12'h000);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset();
      check({9'h000, done, ser_oe, osc_b}, 12'h001);
      $display("reset test over");
   endtask

   task automatic t_enables();
      for (int i = 0; i < 8; i++) begin
         {high_en, low_en, done_en} <= i[2:0];
         cyc(6);
         check({9'h000, high_oe, low_oe, done_oe}, 12'(i));
      end
      {high_en, low_en, done_en} <= 3'h7;
      $display("enable test over");
   endtask

   task automatic t_internal();
      run_conv(12'hA5C, 12'hA5C, 12);
      run_conv(12'hFFF, 12'hFFF, 12);
      run_conv(12'h000, 12'h000, 12);
      run_conv(12'h800, 12'h800, 12);
      $display("internal clock test over");
   endtask

   task automatic t_short();
      full <= 1'b0;
      run_conv(12'h3C7, 12'h3C0, 8);
      full <= 1'b1;
      $display("short conversion test over");
   endtask

   task automatic t_external();
      src <= 1'b0;
      ext_en <= 1'b1;
      run_conv(12'h5A5, 12'h5A5, 12);
      ext_en <= 1'b0;
      src <= 1'b1;
      $display("external clock test over");
   endtask

   // Run held high with the consumer stalled: the buffer fills and refuses
   task automatic t_runstop();
      int n = 0;
      int last_i = 0;
      int gap = 0;
      logic pd = 1'b1;
      rs <= 1'b1;
      tgt <= 12'h6B3;
      run <= 1'b1;
      for (int i = 0; i < 5000; i++) begin
         @(posedge clk);
         if (done === 1'b1 && pd !== 1'b1) begin
            if (n > 0) gap = i - last_i;
            last_i = i;
            n++;
         end
         pd = done;
      end
      check(n[11:0], 12'h004);
      check(gap[11:0], 12'(32 * TICKS_FULL));
      run <= 1'b0;
      cyc(5);
      for (int i = 0; i < 4; i++) pop(12'h6B3);
      check({11'h000, valid}, 12'h000);
      run <= 1'b1;
      wait_for(0, 1'b0, 600);
      cyc(160);
      run <= 1'b0;
      cyc(2);
      check({11'h000, done}, 12'h000);
      wait_for(0, 1'b1, 1000);
      check(bits, 12'h6B3);
      cyc(600);
      check({10'h000, done, ser_oe}, 12'h002);
      pop(12'h6B3);
      check({11'h000, valid}, 12'h000);
      rs <= 1'b0;
      $display("run stop test over");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      cyc(4);
      rst <= 1'b0;
      cyc(2);
      t_reset();
      t_enables();
      t_internal();
      t_short();
      t_external();
      t_runstop();
      finish_test();
   end
endmodule // sar_adc_conversion_control_bench

`default_nettype wire
